// *** dv/test_uart_async_serial_port.sv ***
// self-checking bench of the serial port through apb and the line
// assumes reload 0xff: one bit is 192 pclk doubled, 384 otherwise
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module test_uart_async_serial_port;
  import uasp_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite;
  logic              pready, pslverr, txd, rxd, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [15:0]       bit_cyc;  // pclk per bit for the far end
  logic [8:0]        got;      // frame popped from the far end
  int                err_count, n_tests, cyc, stalls, n;

  uasp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd));
  uasp_far_end far_u (.pclk(pclk), .bit_cyc(bit_cyc), .txd(txd), .rxd(rxd));

  ////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // hang guard, about twice the expected run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      conclude();
    end
  end

  task conclude;
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one apb transfer, held until pready; an idle cycle follows
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      stalls++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////
  // reset values, unmapped place, read-only stop bit, reload byte
  task automatic t_regs;
    logic [7:0] ids [4];
    ids = '{IDX_PWR, IDX_SCTL, IDX_SERIAL_DATA_BUFFER, IDX_TRLD};
    foreach (ids[i]) begin
      apb(1'b0, ids[i], 8'h00);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'b0, 8'h10, 8'h00);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, IDX_SCTL, 8'h04);
    apb(1'b0, IDX_SCTL, 8'h00);
    `CHK("stop bit ro", 32'h0, rd)
    apb(1'b1, IDX_TRLD, 8'hff);
    apb(1'b0, IDX_TRLD, 8'h00);
    `CHK("reload", 32'hff, rd)
    apb(1'b1, IDX_PWR, 8'h80);
    apb(1'b0, IDX_PWR, 8'h00);
    `CHK("double", 32'h80, rd)
  endtask

  // fill the fifo until it stalls, far end decodes every frame
  task automatic t_tx_burst;
    stalls = 0;
    for (int i = 0; i < 10; i++) apb(1'b1, IDX_SERIAL_DATA_BUFFER, 8'(i * 37 + 1));
    `CHK("fifo stall", 1'b1, stalls > 0)
    while (far_u.rx_q.size() < 10) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      got = far_u.rx_q.pop_front();
      `CHK("tx frame", {1'b1, 8'(i * 37 + 1)}, got)
    end
    apb(1'b0, IDX_SCTL, 8'h00);
    `CHK("tx done", 1'b1, rd[SCTL_TI_BIT])
    repeat (400) @(posedge pclk);
    apb(1'b0, IDX_SCTL, 8'h00);
    `CHK("tx done kept", 1'b1, rd[SCTL_TI_BIT])
    apb(1'b1, IDX_SCTL, 8'h00);
    `CHK("idle line", 1'b1, txd)
  endtask

  // exact length of start plus eight zero bits, at both rates
  task automatic t_tx_timing;
    for (int d = 1; d >= 0; d--) begin
      apb(1'b1, IDX_PWR, {d[0], 7'h0});
      bit_cyc <= d ? 16'd192 : 16'd384;
      apb(1'b1, IDX_SERIAL_DATA_BUFFER, 8'h00);
      // read beside the line watch: a start bit during the read is not missed
      fork
        begin
          apb(1'b0, IDX_SCTL, 8'h00);
          `CHK("tx done early", 1'b0, rd[SCTL_TI_BIT])
        end
        begin
          while (txd !== 1'b0) @(posedge pclk);
          n = 0;
          while (txd === 1'b0) begin
            n++;
            @(posedge pclk);
          end
        end
      join
      `CHK("low run", 9 * (d ? 192 : 384), n)
      n = 0;
      do begin
        apb(1'b0, IDX_SCTL, 8'h00);
        n++;
      end while (rd[SCTL_TI_BIT] !== 1'b1);
      `CHK("tx done soon", 1'b1, n <= 2)
      apb(1'b1, IDX_SCTL, 8'h00);
      // far end decodes at mid stop bit, later than tx-done: wait for it
      while (far_u.rx_q.size() < 1) @(posedge pclk);
      got = far_u.rx_q.pop_front();
      `CHK("timed frame", 9'h100, got)
    end
  endtask

  // reception: disabled, glitch, accept, held, bad stop, recover
  task automatic t_rx;
    apb(1'b1, IDX_PWR, 8'h80);
    bit_cyc <= 16'd192;
    far_u.send(8'h5a, 1'b1);
    repeat (40) @(posedge pclk);
    apb(1'b0, IDX_SCTL, 8'h00);
    `CHK("rx off", 32'h0, rd)
    apb(1'b1, IDX_SCTL, 8'h10);
    far_u.glitch(6);
    repeat (400) @(posedge pclk);
    far_u.send(8'h5a, 1'b1);
    repeat (40) @(posedge pclk);
    apb(1'b0, IDX_SCTL, 8'h00);
    `CHK("rx flags", 32'h15, rd)
    apb(1'b0, IDX_SERIAL_DATA_BUFFER, 8'h00);
    `CHK("rx byte", 32'h5a, rd)
    far_u.send(8'hc3, 1'b1);
    repeat (40) @(posedge pclk);
    apb(1'b0, IDX_SERIAL_DATA_BUFFER, 8'h00);
    `CHK("held byte", 32'h5a, rd)
    apb(1'b1, IDX_SCTL, 8'h10);
    far_u.send(8'h3c, 1'b0);
    repeat (400) @(posedge pclk);
    apb(1'b0, IDX_SCTL, 8'h00);
    `CHK("bad stop", 1'b0, rd[SCTL_RI_BIT])
    far_u.send(8'h96, 1'b1);
    repeat (40) @(posedge pclk);
    apb(1'b0, IDX_SERIAL_DATA_BUFFER, 8'h00);
    `CHK("recovered", 32'h96, rd)
  endtask

  // send and receive at once, at the undoubled rate
  task automatic t_duplex;
    apb(1'b1, IDX_PWR, 8'h00);
    bit_cyc <= 16'd384;
    apb(1'b1, IDX_SCTL, 8'h10);
    fork
      far_u.send(8'ha7, 1'b1);
      apb(1'b1, IDX_SERIAL_DATA_BUFFER, 8'h69);
    join
    while (far_u.rx_q.size() < 1) @(posedge pclk);
    got = far_u.rx_q.pop_front();
    `CHK("duplex tx", 9'h169, got)
    apb(1'b0, IDX_SERIAL_DATA_BUFFER, 8'h00);
    `CHK("duplex rx", 32'ha7, rd)
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    bit_cyc = 16'd192;
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_tx_burst();
    t_tx_timing();
    t_rx();
    t_duplex();
    conclude();
  end
endmodule

// *** dv/uasp_far_end.sv ***
// far-end model: a remote async serial transmitter and receiver
// assumes the bench sets bit_cyc to the pclk count of one bit
`timescale 1ns/100ps

module uasp_far_end (
  input  wire logic        pclk,
  input  wire logic [15:0] bit_cyc,
  input  wire logic        txd,
  output logic             rxd
);
  logic [8:0] rx_q [$];  // decoded frames, stop bit on top
  logic [8:0] v;         // frame being decoded

  ////////////////////////////////////////////////////////////////////
  // line idles at the stop level
  initial rxd = 1'b1;

  // one frame, start low, data lsb first, then the given stop level
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge pclk);
    end
    rxd <= 1'b1;
    // one edge passes so a following call never drives rxd twice
    @(posedge pclk);
  endtask

  // short low pulse, too short to survive the mid-bit vote
  task automatic glitch(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge pclk);
    rxd <= 1'b1;
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////
  // receiver: sample mid-bit, keep start-valid frames only
  initial forever begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge pclk);
    if (txd === 1'b0) begin
      for (int i = 0; i < 9; i++) begin
        repeat (bit_cyc) @(posedge pclk);
        v[i] = txd;
      end
      rx_q.push_back(v);
    end
  end
endmodule

// *** logic/uasp_pkg.sv ***
// constants, types and register map of the asynchronous serial port
// assumes an apb slave wrapper in the core file and a 25 MHz pclk
package uasp_pkg;

  localparam int ADDR_W = 10;  // byte address width, word aligned
  localparam int DATA_W = 8;   // serial byte width
  localparam int FIFO_D = 8;   // transmit fifo depth

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PWR  = 8'h87;  // power_control_reg
  localparam logic [7:0] IDX_SCTL = 8'h98;  // serial_control_reg
  localparam logic [7:0] IDX_SERIAL_DATA_BUFFER = 8'h99;  // serial_data_buffer_reg
  localparam logic [7:0] IDX_TCNT = 8'h8b;  // second_timer_count_byte
  localparam logic [7:0] IDX_TRLD = 8'h8d;  // reload_value_byte

  // field positions
  localparam int PWR_DBL_BIT  = 7;  // baud_double
  localparam int SCTL_REN_BIT = 4;  // receive enable
  localparam int SCTL_RB8_BIT = 2;  // received_stop_bit
  localparam int SCTL_TI_BIT  = 1;  // transmit_done_flag
  localparam int SCTL_RI_BIT  = 0;  // receive_done_flag

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;

  // cycle counts
  localparam logic [3:0] TMR_PRE_LAST = 4'hb;  // pclk divided by 12
  localparam logic [7:0] TMR_TOP      = 8'hff; // overflow point
  localparam logic [3:0] DIV_LAST     = 4'hf;  // sixteen slices per bit
  localparam logic [3:0] SMP_A        = 4'h7;  // 8th state
  localparam logic [3:0] SMP_B        = 4'h8;  // 9th state
  localparam logic [3:0] SMP_C        = 4'h9;  // 10th state, vote here
  localparam logic [3:0] FRAME_BITS   = 4'ha;  // start + 8 data + stop
  localparam logic [3:0] STOP_IDX     = 4'h9;  // stop bit position

  typedef enum {RX_IDLE, RX_BUSY} uasp_rx_state_t;

  typedef struct packed {
    logic             stop;  // received stop bit
    logic [DATA_W-1:0] data; // received byte
  } uasp_rx_frame_t;

endpackage

// *** logic/uasp_top.sv ***
// asynchronous serial port core: apb slave, baud timer, tx fifo,
// transmitter and receiver; assumes the far end keeps ten-bit framing
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
// transmit fifo, width and depth as parameters, depth a power of two
module uasp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int PW = $clog2(D);

  logic [W-1:0] mem_ff [D];  // storage words
  logic [PW:0]  wr_ff;       // write pointer with wrap bit
  logic [PW:0]  rd_ff;       // read pointer with wrap bit

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ff[PW] != rd_ff[PW]) && (wr_ff[PW-1:0] == rd_ff[PW-1:0]));
  assign out_valid = (wr_ff != rd_ff);
  assign out_data  = mem_ff[rd_ff[PW-1:0]];

  // pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end

  // storage; no reset needed, empty flag guards stale words
  always_ff @(posedge pclk) begin
    if (in_valid && in_ready) begin
      mem_ff[wr_ff[PW-1:0]] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// serial port top
module uasp_top (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [uasp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            txd,
  input  wire logic                       rxd
);
  import uasp_pkg::*;
  // every check below runs on pclk and sleeps through reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  //////////////////////////////////////////////////////////////////////
  // apb decode
  logic [7:0] idx;        // register index
  logic       hit;        // mapped address
  logic       acc;        // access phase
  logic       wr_serial_data_buffer;    // buffer write request
  logic       fifo_rdy;   // fifo has room
  logic       wr_done;    // write takes effect this edge

  assign idx     = paddr[ADDR_W-1:2];
  assign hit     = (idx == IDX_PWR) || (idx == IDX_SCTL) || (idx == IDX_SERIAL_DATA_BUFFER)
                || (idx == IDX_TCNT) || (idx == IDX_TRLD);
  assign acc     = psel && penable;
  assign wr_serial_data_buffer = acc && pwrite && (idx == IDX_SERIAL_DATA_BUFFER);
  // a full fifo stretches the access phase: back-pressure to software
  assign pready  = !(wr_serial_data_buffer && !fifo_rdy);
  assign pslverr = acc && !hit;
  assign wr_done = acc && pwrite && pready && hit;
  fifo_stall_a: assert property (wr_serial_data_buffer && !fifo_rdy |-> !pready)
    else $error("write accepted into full fifo");

  //////////////////////////////////////////////////////////////////////
  // software registers
  logic           dbl_ff;   // baud_double
  logic           ren_ff;   // receive enable
  logic           rb8_ff;   // received_stop_bit
  logic           ti_ff;    // transmit_done_flag
  logic           ri_ff;    // receive_done_flag
  logic [7:0]     trld_ff;  // reload_value_byte
  uasp_rx_frame_t rxbuf_ff; // receive buffer
  logic           ti_set;   // from transmitter
  logic           rx_commit;// from receiver
  uasp_rx_frame_t rx_frame; // frame to store

  // control bits; a hardware set beats a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbl_ff  <= 1'b0;
      ren_ff  <= 1'b0;
      ti_ff   <= 1'b0;
      ri_ff   <= 1'b0;
      trld_ff <= RST_BYTE;
    end else begin
      if (wr_done && idx == IDX_PWR) begin
        dbl_ff <= pwdata[PWR_DBL_BIT];
      end
      if (wr_done && idx == IDX_SCTL) begin
        ren_ff <= pwdata[SCTL_REN_BIT];
      end
      if (wr_done && idx == IDX_TRLD) begin
        trld_ff <= pwdata[7:0];
      end
      ti_ff <= ti_set | ((wr_done && idx == IDX_SCTL) ? pwdata[SCTL_TI_BIT] : ti_ff);
      ri_ff <= rx_commit | ((wr_done && idx == IDX_SCTL) ? pwdata[SCTL_RI_BIT] : ri_ff);
    end
  end

  // receive buffer and stop bit, loaded only on accepted frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_ff <= '0;
      rb8_ff   <= 1'b0;
    end else if (rx_commit) begin
      rxbuf_ff <= rx_frame;
      rb8_ff   <= rx_frame.stop;
    end
  end
  rx_hold_a: assert property (ri_ff && !(wr_done && idx == IDX_SCTL)
                              |=> $stable(rxbuf_ff))
    else $error("buffer overwritten while rx-done set");

  //////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase so prdata is a flop
  logic [31:0] prdata_ff;  // read data
  logic [7:0]  tcnt_ff;    // second_timer_count_byte
  logic [7:0]  rd_byte;    // selected register

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_PWR:  rd_byte = {dbl_ff, 7'h00};
      IDX_SCTL: rd_byte = {3'h0, ren_ff, 1'b0, rb8_ff, ti_ff, ri_ff};  // no mode field
      IDX_SERIAL_DATA_BUFFER: rd_byte = rxbuf_ff.data;
      IDX_TCNT: rd_byte = tcnt_ff;
      IDX_TRLD: rd_byte = trld_ff;
      default:  rd_byte = 8'h00;  // unmapped reads zero, with pslverr
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (psel && !penable) begin
      prdata_ff <= {24'h000000, rd_byte};
    end
  end
  assign prdata = prdata_ff;

  //////////////////////////////////////////////////////////////////////
  // second timer: pclk/12 prescale, 8-bit auto-reload
  logic [3:0] pre_ff;   // prescaler
  logic       ovf;      // overflow tick
  logic       half_ff;  // halves overflow rate when not doubled
  logic       tick16;   // sixteen times the bit rate

  assign ovf = (pre_ff == TMR_PRE_LAST) && (tcnt_ff == TMR_TOP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff  <= 4'h0;
      tcnt_ff <= RST_BYTE;
    end else begin
      pre_ff <= (pre_ff == TMR_PRE_LAST) ? 4'h0 : pre_ff + 4'h1;
      if (wr_done && idx == IDX_TCNT) begin
        tcnt_ff <= pwdata[7:0];
      end else if (pre_ff == TMR_PRE_LAST) begin
        tcnt_ff <= ovf ? trld_ff : tcnt_ff + 8'h01;
      end
    end
  end
  timer_reload_a: assert property (ovf && !(wr_done && idx == IDX_TCNT)
                                   |=> tcnt_ff == $past(trld_ff))
    else $error("timer did not reload");

  // divide by 2 then 16 gives 1/32; doubled skips the halving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff <= 1'b0;
    end else if (ovf) begin
      half_ff <= !half_ff;
    end
  end
  assign tick16 = ovf && (dbl_ff || half_ff);
  rate_slow_a: assert property (tick16 && !dbl_ff |-> ovf && half_ff)
    else $error("bit tick too fast when not doubled");
  rate_fast_a: assert property (ovf && dbl_ff |-> tick16)
    else $error("bit tick missed when doubled");

  //////////////////////////////////////////////////////////////////////
  // transmitter: free-running divide-by-16, not tied to the write
  logic [7:0] fifo_dat;  // next byte
  logic       fifo_vld;  // byte waiting
  logic       tx_pop;    // take byte
  logic [3:0] txdiv_ff;  // divide-by-16
  logic       roll;      // roll-over
  logic [9:0] txsh_ff;   // frame shifter
  logic [3:0] txcnt_ff;  // bits still to drive
  logic       txd_ff;    // line

  uasp_fifo #(.W(DATA_W), .D(FIFO_D)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (wr_serial_data_buffer),
    .in_ready  (fifo_rdy),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_vld),
    .out_ready (tx_pop),
    .out_data  (fifo_dat)
  );

  assign roll   = tick16 && (txdiv_ff == DIV_LAST);
  assign tx_pop = (txcnt_ff == 4'h0);
  assign ti_set = roll && (txcnt_ff == 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txdiv_ff <= 4'h0;
    end else if (tick16) begin
      txdiv_ff <= txdiv_ff + 4'h1;
    end
  end

  // one bit per roll-over; loading waits for the previous stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txsh_ff  <= 10'h3ff;
      txcnt_ff <= 4'h0;
      txd_ff   <= 1'b1;
    end else if (tx_pop && fifo_vld) begin
      txsh_ff  <= {1'b1, fifo_dat, 1'b0};
      txcnt_ff <= FRAME_BITS;
    end else if (roll && txcnt_ff != 4'h0) begin
      txd_ff   <= txsh_ff[0];
      txsh_ff  <= {1'b1, txsh_ff[9:1]};
      txcnt_ff <= txcnt_ff - 4'h1;
    end
  end
  assign txd = txd_ff;
  sequence first_roll_s;
    roll && txcnt_ff == FRAME_BITS;
  endsequence
  sequence stop_driven_s;
    roll && txcnt_ff == 4'h1;
  endsequence
  line_idle_a: assert property (txcnt_ff == 4'h0 |-> txd_ff)
    else $error("line not idle high between frames");
  start_low_a: assert property (first_roll_s |=> !txd_ff)
    else $error("start bit not low");
  ti_after_stop_a: assert property (stop_driven_s |=> ti_ff && txd_ff)
    else $error("tx-done not set with stop bit");

  //////////////////////////////////////////////////////////////////////
  // receiver input: three flops, change accepted when last two agree
  logic           s1_ff, s2_ff, s3_ff;  // synchroniser
  logic           rxin_ff;   // filtered line
  logic           fall;      // filtered falling edge
  uasp_rx_state_t rxst_ff;   // receiver state
  logic [3:0]     rxdiv_ff;  // receive divide-by-16
  logic [3:0]     rxidx_ff;  // bit position
  logic           va_ff, vb_ff;  // first two votes
  logic           vote;      // majority
  logic           decide;    // third sample instant
  logic [7:0]     rxsh_ff;   // data shifter

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff   <= 1'b1;
      s2_ff   <= 1'b1;
      s3_ff   <= 1'b1;
      rxin_ff <= 1'b1;
    end else begin
      s1_ff <= rxd;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        rxin_ff <= s3_ff;
      end
    end
  end
  assign fall = rxin_ff && (s2_ff == s3_ff) && !s3_ff;

  assign decide = tick16 && (rxdiv_ff == SMP_C);
  assign vote   = (va_ff & vb_ff) | (va_ff & rxin_ff) | (vb_ff & rxin_ff);
  // keeps the buffer from being overwritten while ri is set
  assign rx_commit = (rxst_ff == RX_BUSY) && decide && (rxidx_ff == STOP_IDX)
                  && !ri_ff && vote;
  assign rx_frame  = '{stop: vote, data: rxsh_ff};

  // receiver sequence; independent of the transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxst_ff  <= RX_IDLE;
      rxdiv_ff <= 4'h0;
      rxidx_ff <= 4'h0;
      va_ff    <= 1'b1;
      vb_ff    <= 1'b1;
      rxsh_ff  <= 8'h00;
    end else begin
      case (rxst_ff)
        RX_IDLE: begin
          if (ren_ff && fall) begin
            rxst_ff  <= RX_BUSY;
            rxdiv_ff <= 4'h0;
            rxidx_ff <= 4'h0;
          end
        end
        RX_BUSY: begin
          if (tick16) begin
            rxdiv_ff <= rxdiv_ff + 4'h1;
            if (rxdiv_ff == SMP_A) begin
              va_ff <= rxin_ff;
            end
            if (rxdiv_ff == SMP_B) begin
              vb_ff <= rxin_ff;
            end
          end
          if (decide) begin
            rxidx_ff <= rxidx_ff + 4'h1;
            if (rxidx_ff == 4'h0 && vote) begin
              rxst_ff <= RX_IDLE;
            end else if (rxidx_ff == STOP_IDX) begin
              rxst_ff <= RX_IDLE;
            end else if (rxidx_ff != 4'h0) begin
              rxsh_ff <= {vote, rxsh_ff[7:1]};
            end
          end
        end
        default: rxst_ff <= RX_IDLE;
      endcase
    end
  end
  rx_disabled_a: assert property (rxst_ff == RX_IDLE && !ren_ff |=> rxst_ff == RX_IDLE)
    else $error("receiver started while disabled");
  edge_align_a: assert property (rxst_ff == RX_IDLE && ren_ff && fall
                                 |=> rxst_ff == RX_BUSY && rxdiv_ff == 4'h0)
    else $error("falling edge did not align divider");
  bad_start_a: assert property (rxst_ff == RX_BUSY && decide && rxidx_ff == 4'h0 && vote
                                |=> rxst_ff == RX_IDLE)
    else $error("false start not aborted");
  rx_store_a: assert property (rx_commit |=> ri_ff && rb8_ff
                               && rxbuf_ff.data == $past(rxsh_ff))
    else $error("accepted frame not stored");
endmodule
